// ---- hw/pbsp_pkg.sv ----
// Constants and types shared by the pipelined burst memory port
package pbsp_pkg;
    // Array organisation (wide arrangement: four lanes of eight data plus one parity)
    localparam int          PBSP_ADDR_W    = 19;
    localparam int          PBSP_DATA_W    = 36;
    localparam int          PBSP_LANES     = 4;
    localparam int          PBSP_LANE_W    = 9;
    localparam int          PBSP_WORDS     = 524288;
    localparam int          PBSP_BEAT_W    = 2;
    // Depth of the read-side buffer
    localparam int          PBSP_BUF_DEPTH = 2;
    // Values after reset, and the burst counter step
    localparam logic [35:0] PBSP_WORD_RST  = 36'h0_0000_0000;
    localparam logic [18:0] PBSP_ADDR_RST  = 19'h0_0000;
    localparam logic [1:0]  PBSP_BEAT_RST  = 2'h0;
    localparam logic [1:0]  PBSP_BEAT_ONE  = 2'h1;
    // Lane masks
    localparam logic [3:0]  PBSP_LANE_ALL  = 4'hf;
    localparam logic [3:0]  PBSP_LANE_NONE = 4'h0;
    // Access state, one-hot
    typedef enum logic [2:0] {
        PBSP_ST_IDLE  = 3'b001,
        PBSP_ST_READ  = 3'b010,
        PBSP_ST_WRITE = 3'b100
    } pbsp_state_t;
endpackage : pbsp_pkg

// ---- hw/pbsp_pair_buffer.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pbsp_pair_buffer
    import pbsp_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // Filling side
    input  wire logic                   in_valid,
    output var  logic                   in_ready,
    input  wire logic [PBSP_DATA_W-1:0] in_data,
    // Draining side
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic      [PBSP_DATA_W-1:0] out_data
);
    logic [PBSP_DATA_W-1:0] slot_reg [0:PBSP_BUF_DEPTH-1]; // Storage slots
    logic                   wr_ptr_reg;                     // Next slot to fill
    logic                   rd_ptr_reg;                     // Next slot to drain
    logic [1:0]             count_reg;                      // Words held
    logic [1:0]             count_next;                     // Words held next
    logic                   push;                           // Word accepted
    logic                   pop;                            // Word handed on

    // Handshake terms
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = slot_reg[rd_ptr_reg];

    // Occupancy after this edge
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // Pointers, count and a registered ready that is low only when full
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            in_ready   <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_next;
            in_ready  <= (count_next != 2'h2);
        end
    end

    // Slot write, data only
    always_ff @(posedge clock) begin
        if (push) begin
            slot_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule : pbsp_pair_buffer
`default_nettype wire

// ---- hw/pbsp_burst_port.sv ----
// Pipelined burst static memory: input capture, burst counter, array, read pipe
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - All synchronous inputs captured on rising edge
// - Address loads only on either address strobe
// - Advance steps burst address, otherwise it holds
// - Two-bit counter, four locations per burst
// - Burst order linear or interleaved, user chosen
// - Writes registered together, then self-timed commit
// - Enabled byte lanes written, others keep contents
// - Global write writes every byte lane
// - Output enable and sleep act without clock
// - Read data passes an output register
// - Burst timing three, one, one, one
// - Two independent address strobes start accesses
// - Deselect takes effect in one cycle
// - Array is 512K words of 36 bits
module pbsp_burst_port
    import pbsp_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // Address and selects
    input  wire logic [PBSP_ADDR_W-1:0] address,
    input  wire logic                   chip_select_primary_n,
    input  wire logic                   chip_select_expand_high,
    input  wire logic                   chip_select_expand_low_n,
    // Burst control
    input  wire logic                   processor_address_strobe_n,
    input  wire logic                   controller_address_strobe_n,
    input  wire logic                   burst_advance_n,
    input  wire logic                   burst_order_interleaved,
    // Write control
    input  wire logic [PBSP_LANES-1:0]  byte_lane_write_enable_n,
    input  wire logic                   byte_write_gate_n,
    input  wire logic                   global_write_n,
    // Asynchronous controls
    input  wire logic                   output_enable_n,
    input  wire logic                   sleep_request,
    // Data pins, split into three signals
    input  wire logic [PBSP_DATA_W-1:0] data_in,
    output logic      [PBSP_DATA_W-1:0] data_out,
    output logic                        data_oe,
    // Read stream toward the receiver
    output logic                        read_valid,
    input  wire logic                   read_ready,
    output logic                        port_ready
);
    // Storage array
    logic [PBSP_DATA_W-1:0] array_mem [0:PBSP_WORDS-1];

    // Burst state
    pbsp_state_t            state_reg;                    // Current access kind
    logic [PBSP_ADDR_W-1:0] base_addr_reg;                // Loaded start address
    logic [PBSP_BEAT_W-1:0] beat_reg;                     // Beats taken so far
    logic [PBSP_BEAT_W-1:0] beat_next;                    // Beat after advance
    logic [PBSP_BEAT_W-1:0] burst_low;                    // Low bits of next beat

    // Decoded pin terms
    logic                   strobe_hit;                   // Either strobe active
    logic                   chip_sel;                     // All selects true
    logic [PBSP_LANES-1:0]  lane_req;                     // Lanes asked to write
    logic                   write_req;                    // Any lane asked
    logic                   advance_hit;                  // Advance in a burst
    logic [PBSP_ADDR_W-1:0] access_addr;                  // Address of this beat
    logic                   read_issue;                   // Read starts now
    logic                   write_issue;                  // Write captured now

    // Write stage
    logic                   wr_go_reg;                    // Commit pending
    logic [PBSP_ADDR_W-1:0] wr_addr_reg;                  // Commit address
    logic [PBSP_DATA_W-1:0] wr_data_reg;                  // Commit data
    logic [PBSP_LANES-1:0]  wr_lane_reg;                  // Commit lanes
    logic [PBSP_DATA_W-1:0] wr_merged;                    // Old word with new lanes

    // Read stage
    logic                   rd_go_reg;                    // Read waiting for buffer
    logic [PBSP_ADDR_W-1:0] rd_addr_reg;                  // Read address
    logic                   rd_accept;                    // Read stage may load

    // Buffer to output register
    logic                   buf_in_ready;                 // Buffer has room
    logic                   buf_out_valid;                // Buffer holds a word
    logic                   buf_out_ready;                // Output stage takes one
    logic [PBSP_DATA_W-1:0] buf_out_data;                 // Head word
    logic                   out_valid_reg;                // Output register full

    // Strobe and select decode
    always_comb begin
        strobe_hit = ~processor_address_strobe_n | ~controller_address_strobe_n;
        chip_sel   = ~chip_select_primary_n & chip_select_expand_high
                     & ~chip_select_expand_low_n;
    end

    // Lane decode: global write overrides, else gated byte lanes
    always_comb begin
        if (!global_write_n) begin
            lane_req = PBSP_LANE_ALL;
        end else if (!byte_write_gate_n) begin
            lane_req = ~byte_lane_write_enable_n;
        end else begin
            lane_req = PBSP_LANE_NONE;                             // Read beat
        end
        write_req = |lane_req;
    end

    // Burst address of the following beat
    always_comb begin
        beat_next = beat_reg + PBSP_BEAT_ONE;
        if (burst_order_interleaved) begin
            burst_low = base_addr_reg[PBSP_BEAT_W-1:0] ^ beat_next;
        end else begin
            burst_low = base_addr_reg[PBSP_BEAT_W-1:0] + beat_next;
        end
    end

    // Which beat happens on this edge, and at what address
    always_comb begin
        advance_hit = ~burst_advance_n & ~strobe_hit & (state_reg != PBSP_ST_IDLE);
        if (strobe_hit) begin
            access_addr = address;
        end else begin
            access_addr = {base_addr_reg[PBSP_ADDR_W-1:PBSP_BEAT_W], burst_low};
        end
        read_issue  = ((strobe_hit & chip_sel) | advance_hit) & ~write_req;
        write_issue = ((strobe_hit & chip_sel) | advance_hit) & write_req;
        rd_accept   = ~rd_go_reg | buf_in_ready;
    end

    // Access state: strobes load, deselect drops out in one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PBSP_ST_IDLE;
        end else begin
            case (state_reg)
                PBSP_ST_IDLE, PBSP_ST_READ, PBSP_ST_WRITE: begin
                    if (strobe_hit && !chip_sel) begin
                        state_reg <= PBSP_ST_IDLE;
                    end else if (strobe_hit && write_req) begin
                        state_reg <= PBSP_ST_WRITE;
                    end else if (strobe_hit) begin
                        state_reg <= PBSP_ST_READ;
                    end else if (advance_hit && write_req) begin
                        state_reg <= PBSP_ST_WRITE;                // Burst turns to write
                    end else if (advance_hit) begin
                        state_reg <= PBSP_ST_READ;                 // Burst keeps reading
                    end
                end
                default: begin
                    state_reg <= PBSP_ST_IDLE;                     // Illegal code recovers
                end
            endcase
        end
    end

    // Address register and burst counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            base_addr_reg <= PBSP_ADDR_RST;
            beat_reg      <= PBSP_BEAT_RST;
        end else begin
            if (strobe_hit) begin
                base_addr_reg <= address;
                beat_reg      <= PBSP_BEAT_RST;
            end else if (advance_hit) begin
                beat_reg      <= beat_next;
            end
        end
    end

    // Write capture: address, data and lanes taken on one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_go_reg   <= 1'b0;
            wr_addr_reg <= PBSP_ADDR_RST;
            wr_data_reg <= PBSP_WORD_RST;
            wr_lane_reg <= PBSP_LANE_NONE;
        end else begin
            wr_go_reg <= write_issue;
            if (write_issue) begin
                wr_addr_reg <= access_addr;
                wr_data_reg <= data_in;
                wr_lane_reg <= lane_req;
            end
        end
    end

    // Lane merge: untouched lanes keep the stored contents
    generate
        for (genvar lane = 0; lane < PBSP_LANES; lane++) begin : g_lane
            always_comb begin
                if (wr_lane_reg[lane]) begin
                    wr_merged[lane*PBSP_LANE_W +: PBSP_LANE_W] =
                        wr_data_reg[lane*PBSP_LANE_W +: PBSP_LANE_W];
                end else begin
                    wr_merged[lane*PBSP_LANE_W +: PBSP_LANE_W] =
                        array_mem[wr_addr_reg][lane*PBSP_LANE_W +: PBSP_LANE_W];
                end
            end
        end
    endgenerate

    // Self-timed commit one edge after capture, no master action needed
    always_ff @(posedge clock) begin
        if (wr_go_reg) begin
            array_mem[wr_addr_reg] <= wr_merged;
        end
    end

    // Read stage: holds a read while the buffer is full
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_go_reg   <= 1'b0;
            rd_addr_reg <= PBSP_ADDR_RST;
        end else if (rd_accept) begin
            rd_go_reg <= read_issue;
            if (read_issue) begin
                rd_addr_reg <= access_addr;
            end
        end
    end

    // Buffer between array and output register
    pbsp_pair_buffer u_pair_buffer (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (rd_go_reg),
        .in_ready  (buf_in_ready),
        .in_data   (array_mem[rd_addr_reg]),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // Output register takes a word when empty or being drained
    assign buf_out_ready = ~out_valid_reg | read_ready;

    // Output data register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out      <= PBSP_WORD_RST;
            out_valid_reg <= 1'b0;
        end else if (buf_out_valid && buf_out_ready) begin
            data_out      <= buf_out_data;
            out_valid_reg <= 1'b1;
        end else if (read_ready) begin
            out_valid_reg <= 1'b0;                                 // Word taken
        end
    end

    // Stream flags straight from flops
    assign read_valid = out_valid_reg;
    assign port_ready = buf_in_ready;

    // Drivers follow enable and sleep with no clock in the path
    assign data_oe = out_valid_reg & ~output_enable_n & ~sleep_request;
endmodule : pbsp_burst_port
`default_nettype wire

// ---- dv/pbsp_burst_port_properties.sv ----
// Pin-level checks on the burst memory port
`timescale 1ns/1ps
`default_nettype none
module pbsp_burst_port_chk
    import pbsp_pkg::*;
(
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   rst_n,
    // Request pins
    input wire logic                   chip_select_primary_n,
    input wire logic                   chip_select_expand_high,
    input wire logic                   chip_select_expand_low_n,
    input wire logic                   processor_address_strobe_n,
    input wire logic                   controller_address_strobe_n,
    input wire logic                   burst_advance_n,
    input wire logic [PBSP_LANES-1:0]  byte_lane_write_enable_n,
    input wire logic                   byte_write_gate_n,
    input wire logic                   global_write_n,
    input wire logic                   output_enable_n,
    input wire logic                   sleep_request,
    // Read side
    input wire logic [PBSP_DATA_W-1:0] data_out,
    input wire logic                   data_oe,
    input wire logic                   read_valid,
    input wire logic                   read_ready,
    input wire logic                   port_ready
);
    logic sel;      // All selects true
    logic stb;      // Either strobe low
    logic wr;       // Write controls active
    logic rd;       // Read taken this edge
    logic open_reg; // Burst open
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    assign sel = !chip_select_primary_n && chip_select_expand_high && !chip_select_expand_low_n;
    assign stb = !processor_address_strobe_n || !controller_address_strobe_n;
    assign wr = !global_write_n || (!byte_write_gate_n && byte_lane_write_enable_n != 4'hf);
    assign rd = !wr && ((stb && sel) || (!stb && !burst_advance_n && open_reg));
    // Burst opens on a selected strobe, closes on a deselect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) open_reg <= 1'b0;
        else if (stb) open_reg <= sel;
    end
    oe_follow_a: assert property (data_oe == (read_valid && !output_enable_n && !sleep_request))
        else $error("drive enable wrong");
    read_latency_a: assert property (rd && port_ready && !read_valid |-> ##3 read_valid)
        else $error("read word late");
    valid_cause_a: assert property ($rose(read_valid) |-> $past(rd, 3))
        else $error("word without request");
    stall_hold_a: assert property (read_valid && !read_ready |=> read_valid && $stable(data_out))
        else $error("stalled word lost");
    deselect_a: assert property (stb && !sel ##1 (!stb && !burst_advance_n) |-> ##3 !$rose(read_valid))
        else $error("burst open after deselect");
    full_valid_a: assert property (!port_ready |-> read_valid)
        else $error("full without word");
    beat_stream_a: assert property (rd && port_ready ##1 rd && port_ready |-> ##2 read_valid [*2])
        else $error("beats not one per clock");
    no_spurious_a: assert property (!read_valid && !rd && !$past(rd) && !$past(rd, 2) |=> !read_valid)
        else $error("unrequested word");
endmodule : pbsp_burst_port_chk
bind pbsp_burst_port pbsp_burst_port_chk u_chk (.clock, .rst_n, .chip_select_primary_n,
    .chip_select_expand_high, .chip_select_expand_low_n, .processor_address_strobe_n,
    .controller_address_strobe_n, .burst_advance_n, .byte_lane_write_enable_n,
    .byte_write_gate_n, .global_write_n, .output_enable_n, .sleep_request, .data_out,
    .data_oe, .read_valid, .read_ready, .port_ready);
`default_nettype wire

// ---- dv/pbsp_stream_sink.sv ----
// Receiver model that takes read words, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module pbsp_stream_sink (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // 0 prompt, 1 random stall, 2 hold off
    input  wire logic [1:0] stall_mode,
    output var  logic       read_ready
);
    logic [7:0] pat_reg; // Stall pattern
    // Ready follows the chosen mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pat_reg    <= 8'h5a;
            read_ready <= 1'b0;
        end else begin
            pat_reg    <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
            read_ready <= stall_mode == 2'h0 || (stall_mode == 2'h1 && pat_reg[0]);
        end
    end
endmodule : pbsp_stream_sink
`default_nettype wire

// ---- dv/tb_pbsp_burst_port.sv ----
// Self-checking bench for the burst memory port
`timescale 1ns/1ps
`default_nettype none
module tb_pbsp_burst_port;
    import pbsp_pkg::*;
    logic        clock, rst_n, cp_n, ch, cl_n, ps_n, cs_n, adv_n, ilv, bg_n, gw_n, oe_n, slp;
    logic [18:0] addr, base;     // Pins, burst start
    logic [3:0]  ln_n;           // Lane enables
    logic [35:0] din, dout;      // Data pins
    logic        doe, rv, rdy, prdy, open, over;
    logic [1:0]  mode, beat;     // Sink mode, beat count
    logic [35:0] mem [logic [18:0]]; // Shadow array
    logic [35:0] exp_q [$];      // Words still owed
    logic [31:0] r = 32'h0000_5388;
    int          err_count, n_tests, n_iss, n_take;
    pbsp_burst_port dut (
        .clock(clock), .rst_n(rst_n), .address(addr), .chip_select_primary_n(cp_n),
        .chip_select_expand_high(ch), .chip_select_expand_low_n(cl_n),
        .processor_address_strobe_n(ps_n), .controller_address_strobe_n(cs_n),
        .burst_advance_n(adv_n), .burst_order_interleaved(ilv), .byte_lane_write_enable_n(ln_n),
        .byte_write_gate_n(bg_n), .global_write_n(gw_n), .output_enable_n(oe_n),
        .sleep_request(slp), .data_in(din), .data_out(dout), .data_oe(doe), .read_valid(rv),
        .read_ready(rdy), .port_ready(prdy));
    pbsp_stream_sink sink (.clock(clock), .rst_n(rst_n), .stall_mode(mode), .read_ready(rdy));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // One cycle: 0 idle, 1 strobe, 2 advance, 3 deselect
    task automatic op(input int k, input logic [18:0] a, input logic w, input logic [35:0] d,
                      input logic [3:0] l_n, input logic g_n);
        logic        wr;
        logic [18:0] ea;
        wr = w && (!g_n || l_n != PBSP_LANE_ALL);
        r = lfsr(r);
        if (!wr && !over && k < 3 && n_iss - n_take >= 3) k = 0; // Wait for room
        @(posedge clock);
        ps_n  <= !(k == 1 || k == 3) || r[7];
        cs_n  <= !(k == 1 || k == 3) || !r[7];
        cp_n  <= k == 3 && r[9:8] == 2'h0;
        ch    <= !(k == 3 && r[9:8] == 2'h1);
        cl_n  <= k == 3 && r[9:8] >= 2'h2;
        adv_n <= k != 2;
        addr  <= k == 1 ? a : r[18:0];
        din   <= d;
        gw_n  <= !w || g_n;
        bg_n  <= !w;
        ln_n  <= w ? l_n : r[13:10];
        oe_n  <= r[14] & r[15];
        slp   <= r[16] & r[17] & r[18];
        if (k == 1) base = a;
        if (k == 1) beat = 2'h0;
        open = k == 1 || (open && k != 3);
        if (k == 2 && open) beat = beat + 2'h1;
        ea = {base[18:2], ilv ? base[1:0] ^ beat : base[1:0] + beat};
        if (k == 1 || (k == 2 && open)) begin
            if (wr) begin
                for (int i = 0; i < 4; i++)
                    if (!g_n || !l_n[i]) mem[ea][9*i +: 9] = d[9*i +: 9];
            end else begin
                exp_q.push_back(mem[ea]);
                n_iss++;
            end
        end
    endtask : op
    task automatic do_reset;
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(negedge clock);
        check(36'(rv), 36'h0);
        check(36'(doe), 36'h0);
        check(36'(prdy), 36'h1);
        check(dout, PBSP_WORD_RST);
        @(posedge clock);
        rst_n <= 1'b1;
    endtask : do_reset
    // Compare each word the receiver takes at the coming edge
    always @(negedge clock) begin
        if (rst_n && rv === 1'b1 && rdy === 1'b1) begin
            n_take++;
            if (exp_q.size() == 0) check(36'h1, 36'h0);
            else check(dout, exp_q.pop_front());
        end
    end
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        test_done;
    end
    initial begin
        {ps_n, cs_n, adv_n, ch, bg_n, gw_n, oe_n} = 7'h7f;
        {rst_n, cp_n, cl_n, ilv, slp, over, open, beat, base} = '0;
        {addr, ln_n, din, mode} = '0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            ilv <= p[0];
            for (int i = 0; i < 16; i++)
                op(1, 19'(i), 1'b1, {r[3:0], lfsr(r)}, r[7:4], 1'b0);
            for (int i = 0; i < 4; i++)
                op(1, 19'h7_fffc + 19'(i), 1'b1, {r[3:0], r}, 4'hf, 1'b0);
            // Burst from an odd start, fifth beat wraps
            op(1, 19'h7_fffd, 1'b0, 36'h0, 4'hf, 1'b1);
            repeat (4) op(2, 19'h0, 1'b0, 36'h0, 4'hf, 1'b1);
            // Partial lane writes, then read back
            foreach (ln_n[j]) op(1, 19'h9, 1'b1, {r[3:0], r}, ~(4'h1 << j), 1'b1);
            op(1, 19'h9, 1'b1, {r[3:0], r}, 4'h3, 1'b1);
            op(1, 19'h9, 1'b0, 36'h0, 4'hf, 1'b1);
            op(3, 19'h0, 1'b0, 36'h0, 4'hf, 1'b1);
            op(2, 19'h0, 1'b0, 36'h0, 4'hf, 1'b1);
            // Receiver holds off until the buffer refuses
            mode <= 2'h2;
            over = 1'b1;
            for (int i = 0; i < 6 && prdy !== 1'b0; i++) begin
                op(1, 19'(i), 1'b0, 36'h0, 4'hf, 1'b1);
                repeat (2) op(0, 19'h0, 1'b0, 36'h0, 4'hf, 1'b1);
                @(negedge clock);
            end
            check(36'(prdy), 36'h0);
            over = 1'b0;
            mode <= 2'h1;
            for (int i = 0; i < 300; i++)
                op(r[1:0], {15'h0, r[22:19]}, r[3] & r[4], {r[3:0], lfsr(r)}, r[27:24], r[5]);
            repeat (200) if (exp_q.size() != 0) @(posedge clock);
            check(36'(exp_q.size()), 36'h0);
            do_reset;
        end
        test_done;
    end
endmodule : tb_pbsp_burst_port
`default_nettype wire
